// ===== pkg/fspc_params.svh
// Constants for the flash self-program controller: bit positions, timing, reset values.
// Assumes a 25 MHz system clock and a 32-word page of 16-bit words.
// Summary of operation
// - Store target comes from a 16-bit pointer: low bits word, upper bits page.
// - Erase or write latches its page; later pointer changes do not matter.
// - Program-memory load uses the full pointer as byte address, bit 0 picks byte.
// - Pattern X0000011 then store erases the page; operand and word bits ignored.
// - Erase or write of the no-read-while-write section halts the core.
// - Pattern 00000001 then store loads the operand into the addressed buffer slot.
// - Buffer clears after page write, a re-enable write while idle, and reset.
// - Each buffer slot takes one load between clears.
// - An EEPROM write during page loading discards all loaded words.
// - Buffer loads in any order, before erase or between erase and write.
// - Enabled interrupt request stays high while the enable bit is clear.
// - Read-while-write section reads blocked during programming; busy flag held.
// - Writing the re-enable bit while idle clears the section busy flag.
// - Pattern X0001001 then store programs locks from operand bits 5..0.
// - Zero operand bits program their lock bit; ones leave it unchanged.
// - Lock programming keeps all memory readable and never stalls the core.
// - EEPROM write in progress refuses all program and lock operations and lock-bit reads.
// - Enable and lock-select clear without store in four cycles; a lock-bit load in the first three also clears them.
// - Lock bits: one is unprogrammed, zero is programmed.
// - Each erase, write or lock write lasts 3.7 ms to 4.5 ms.
`ifndef FSPC_PARAMS_SVH
`define FSPC_PARAMS_SVH
`define FSPC_EN_BIT 0
`define FSPC_ERASE_BIT 1
`define FSPC_WRITE_BIT 2
`define FSPC_LSEL_BIT 3
`define FSPC_REEN_BIT 4
`define FSPC_IRQEN_BIT 7
`define FSPC_WORD_LSB 1
`define FSPC_WORD_MSB 5
`define FSPC_PAGE_LSB 6
`define FSPC_NO_READ_WHILE_WRITE_SECTION_PAGE 10'h380
`define FSPC_LOCK_PTR 16'h0001
`define FSPC_LOCK_RST 6'h3f
`define FSPC_ERASED_WORD 16'hffff
`define FSPC_STORE_WIN 3'h4
`define FSPC_LOAD_WIN 3'h3
`define FSPC_CLK_PERIOD_NS 40
`define FSPC_OP_MIN_NS 3700000
`define FSPC_OP_MAX_NS 4500000
`define FSPC_OP_CYCLES ((`FSPC_OP_MIN_NS + `FSPC_CLK_PERIOD_NS - 1) / `FSPC_CLK_PERIOD_NS)
`endif

// ===== pkg/fspc_pkg.sv
// Types of the flash self-program controller.
// Widths follow a 16-bit pointer, 10-bit page index and 32-word page.
package fspc_pkg;
    typedef enum logic [2:0] {FSPC_IDLE = 3'b001, FSPC_ARM = 3'b010, FSPC_BUSY = 3'b100}
        fspc_state_type;
    typedef enum logic [1:0] {FSPC_K_LOAD, FSPC_K_ERASE, FSPC_K_WRITE, FSPC_K_LOCK}
        fspc_kind_type;
    typedef struct packed {logic we; logic [7:0] wdata;} fspc_csr_type;
    typedef struct packed {logic store; logic load; logic [15:0] ptr; logic [15:0] operand;}
        fspc_req_type;
    typedef struct packed {logic start; fspc_kind_type kind; logic [9:0] page;} fspc_op_type;
    typedef struct packed {logic valid; logic [14:0] word; logic hi;} fspc_rd_type;
    typedef struct packed {
        fspc_state_type st;
        fspc_kind_type kind;
        logic en;
        logic erase;
        logic write;
        logic lsel;
        logic irq_en;
        logic sbusy;
        logic halt;
        logic irq;
        logic [2:0] win;
        logic [16:0] cnt;
        logic [5:0] lockv;
        logic [5:0] lock;
        fspc_op_type op;
        fspc_rd_type rd;
        logic ld_valid;
        logic [7:0] ld_data;
    } fspc_regs_type;
    typedef struct packed {
        logic [31:0][15:0] mem;
        logic [31:0] full;
        logic [15:0] rd_data;
    } fspc_buf_type;
endpackage

// ===== rtl/fspc_page_buf.sv
// Temporary page buffer: 32 words of 16 bits with a fill mark per slot.
// Assumes clear and write come from controller logic on the same clock.
`timescale 1ns/1ps
`include "fspc_params.svh"
module fspc_page_buf
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Control
    input wire logic i_clr,
    input wire logic i_wr,
    input wire logic [4:0] i_wr_idx,
    input wire logic [15:0] i_wr_data,
    // Read port
    input wire logic [4:0] i_rd_idx,
    output logic [15:0] o_rd_data
);
    fspc_pkg::fspc_buf_type q, n;

    always_comb
    begin
        n = q;
        if (i_clr)
        begin
            n.full = '0;
        end
        if (i_wr && !n.full[i_wr_idx])
        begin
            n.mem[i_wr_idx] = i_wr_data;
            n.full[i_wr_idx] = 1'b1;
        end
        n.rd_data = q.full[i_rd_idx] ? q.mem[i_rd_idx] : `FSPC_ERASED_WORD;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            q <= '0;
        end
        else
        begin
            q <= n;
        end
    end

    assign o_rd_data = q.rd_data;
endmodule

// ===== rtl/fspc_ctrl.sv
// Flash self-program controller: control register, store and load sequencing, timing.
// Assumes the core presents store and load as one-cycle strobes on the system clock.
`timescale 1ns/1ps
`include "fspc_params.svh"
module fspc_ctrl
#(
    parameter int P_OP_CYCLES = `FSPC_OP_CYCLES
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Control register access
    input wire fspc_pkg::fspc_csr_type i_csr,
    output logic [7:0] o_csr_rdata,
    // Core store and load requests
    input wire fspc_pkg::fspc_req_type i_req,
    output logic o_ld_valid,
    output logic [7:0] o_ld_data,
    output logic o_core_halt,
    output logic o_irq,
    // EEPROM status
    input wire logic i_eeprom_busy,
    input wire logic i_eeprom_wr_start,
    // Flash array side
    output fspc_pkg::fspc_op_type o_op,
    output fspc_pkg::fspc_rd_type o_rd,
    output logic o_sect_busy,
    output logic [5:0] o_lock,
    input wire logic [4:0] i_buf_idx,
    output logic [15:0] o_buf_data
);
    fspc_pkg::fspc_regs_type q, n;
    logic buf_clr;
    logic buf_wr;
    logic [9:0] req_page;

    function automatic logic is_no_read_while_write_section(input logic [9:0] page);
        is_no_read_while_write_section = page >= `FSPC_NO_READ_WHILE_WRITE_SECTION_PAGE;
    endfunction

    assign req_page = i_req.ptr[15:`FSPC_PAGE_LSB];

    always_comb
    begin
        n = q;
        buf_clr = 1'b0;
        buf_wr = 1'b0;
        n.op.start = 1'b0;
        n.rd.valid = 1'b0;
        n.ld_valid = 1'b0;
        case (q.st)
            fspc_pkg::FSPC_IDLE:
            begin
                if (i_csr.we && !i_eeprom_busy)
                begin
                    n.irq_en = i_csr.wdata[`FSPC_IRQEN_BIT];
                    if (i_csr.wdata[`FSPC_REEN_BIT])
                    begin
                        buf_clr = 1'b1;
                        n.sbusy = 1'b0;
                    end
                    else if (i_csr.wdata[`FSPC_EN_BIT])
                    begin
                        n.en = 1'b1;
                        n.erase = i_csr.wdata[`FSPC_ERASE_BIT];
                        n.write = i_csr.wdata[`FSPC_WRITE_BIT];
                        n.lsel = i_csr.wdata[`FSPC_LSEL_BIT];
                        n.win = '0;
                        n.st = fspc_pkg::FSPC_ARM;
                    end
                end
            end
            fspc_pkg::FSPC_ARM:
            begin
                n.win = q.win + 3'h1;
                if (i_req.store && !i_eeprom_busy)
                begin
                    n.op.page = req_page;
                    n.cnt = '0;
                    if (q.erase)
                    begin
                        n.kind = fspc_pkg::FSPC_K_ERASE;
                    end
                    else if (q.write)
                    begin
                        n.kind = fspc_pkg::FSPC_K_WRITE;
                    end
                    else if (q.lsel)
                    begin
                        n.kind = fspc_pkg::FSPC_K_LOCK;
                        n.lockv = i_req.operand[5:0];
                    end
                    else
                    begin
                        n.kind = fspc_pkg::FSPC_K_LOAD;
                        buf_wr = 1'b1;
                    end
                    if (n.kind == fspc_pkg::FSPC_K_LOAD)
                    begin
                        n.en = 1'b0;
                        n.st = fspc_pkg::FSPC_IDLE;
                    end
                    else
                    begin
                        n.op.start = 1'b1;
                        n.op.kind = n.kind;
                        n.st = fspc_pkg::FSPC_BUSY;
                        if (n.kind != fspc_pkg::FSPC_K_LOCK)
                        begin
                            n.sbusy = 1'b1;
                            n.halt = is_no_read_while_write_section(req_page);
                        end
                    end
                end
                else if (i_req.load && q.lsel && q.win < `FSPC_LOAD_WIN && !i_eeprom_busy)
                begin
                    n.ld_valid = 1'b1;
                    n.ld_data = (i_req.ptr == `FSPC_LOCK_PTR) ? {2'b11, q.lock} : 8'hff;
                    n.en = 1'b0;
                    n.lsel = 1'b0;
                    n.st = fspc_pkg::FSPC_IDLE;
                end
                else if (q.win == `FSPC_STORE_WIN - 3'h1)
                begin
                    n.en = 1'b0;
                    n.erase = 1'b0;
                    n.write = 1'b0;
                    n.lsel = 1'b0;
                    n.st = fspc_pkg::FSPC_IDLE;
                end
            end
            fspc_pkg::FSPC_BUSY:
            begin
                n.cnt = q.cnt + 17'h1;
                if (q.cnt == 17'(P_OP_CYCLES - 1))
                begin
                    n.st = fspc_pkg::FSPC_IDLE;
                    n.en = 1'b0;
                    n.erase = 1'b0;
                    n.write = 1'b0;
                    n.lsel = 1'b0;
                    n.halt = 1'b0;
                    if (q.kind == fspc_pkg::FSPC_K_WRITE)
                    begin
                        buf_clr = 1'b1;
                    end
                    if (q.kind == fspc_pkg::FSPC_K_LOCK)
                    begin
                        n.lock = q.lock & q.lockv;
                    end
                end
            end
            default:
            begin
                n.st = fspc_pkg::FSPC_IDLE;
            end
        endcase
        if (i_req.load && !(q.st == fspc_pkg::FSPC_ARM && q.lsel))
        begin
            if (q.sbusy && !is_no_read_while_write_section(req_page))
            begin
                n.rd.valid = 1'b0;
            end
            else
            begin
                n.rd.valid = 1'b1;
                n.rd.word = i_req.ptr[15:1];
                n.rd.hi = i_req.ptr[0];
            end
        end
        if (i_eeprom_wr_start)
        begin
            buf_clr = 1'b1;
        end
        n.irq = n.irq_en && !n.en;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            q <= '0;
            q.st <= fspc_pkg::FSPC_IDLE;
            q.lock <= `FSPC_LOCK_RST;
        end
        else
        begin
            q <= n;
        end
    end

    fspc_page_buf u_buf
    (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_clr(buf_clr),
        .i_wr(buf_wr),
        .i_wr_idx(i_req.ptr[`FSPC_WORD_MSB:`FSPC_WORD_LSB]),
        .i_wr_data(i_req.operand),
        .i_rd_idx(i_buf_idx),
        .o_rd_data(o_buf_data)
    );

    assign o_csr_rdata = {q.irq_en, q.sbusy, 2'b00, q.lsel, q.write, q.erase, q.en};
    assign o_ld_valid = q.ld_valid;
    assign o_ld_data = q.ld_data;
    assign o_core_halt = q.halt;
    assign o_irq = q.irq;
    assign o_op = q.op;
    assign o_rd = q.rd;
    assign o_sect_busy = q.sbusy;
    assign o_lock = q.lock;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    property p_page_held;
        q.st == fspc_pkg::FSPC_BUSY && $past(q.st) == fspc_pkg::FSPC_BUSY |-> $stable(q.op.page);
    endproperty
    a_page_held: assert property (p_page_held) else $error("page changed during op");

    property p_halt_no_read_while_write_section;
        q.st == fspc_pkg::FSPC_BUSY && q.kind != fspc_pkg::FSPC_K_LOCK && is_no_read_while_write_section(q.op.page)
            |-> o_core_halt;
    endproperty
    a_halt_no_read_while_write_section: assert property (p_halt_no_read_while_write_section) else $error("core not halted");

    property p_lock_no_halt;
        q.kind == fspc_pkg::FSPC_K_LOCK && q.st == fspc_pkg::FSPC_BUSY |-> !o_core_halt;
    endproperty
    a_lock_no_halt: assert property (p_lock_no_halt) else $error("halt in lock op");

    property p_irq_level;
        o_irq == (o_csr_rdata[`FSPC_IRQEN_BIT] && !o_csr_rdata[`FSPC_EN_BIT]);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

    property p_sect_busy;
        o_op.start && o_op.kind != fspc_pkg::FSPC_K_LOCK |-> o_sect_busy;
    endproperty
    a_sect_busy: assert property (p_sect_busy) else $error("busy flag not set");

    property p_arm_window;
        q.st == fspc_pkg::FSPC_ARM |-> q.win < `FSPC_STORE_WIN;
    endproperty
    a_arm_window: assert property (p_arm_window) else $error("armed too long");

    property p_op_length;
        $fell(q.st == fspc_pkg::FSPC_BUSY) |-> $past(q.cnt) == 17'(P_OP_CYCLES - 1);
    endproperty
    a_op_length: assert property (p_op_length) else $error("op length wrong");

    property p_en_busy;
        o_op.start |-> q.en ##1 (q.en || q.st == fspc_pkg::FSPC_IDLE);
    endproperty
    a_en_busy: assert property (p_en_busy) else $error("enable dropped early");

    property p_ee_refuse;
        i_eeprom_busy && i_req.store |=> !o_op.start;
    endproperty
    a_ee_refuse: assert property (p_ee_refuse) else $error("op during eeprom write");

    property p_busy_ignore;
        q.st == fspc_pkg::FSPC_BUSY && i_csr.we |=> $stable(q.kind) && $stable(q.irq_en);
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("write taken in op");

    property p_reen_clear;
        q.st == fspc_pkg::FSPC_IDLE && i_csr.we && !i_eeprom_busy
            && i_csr.wdata[`FSPC_REEN_BIT] |=> !o_sect_busy;
    endproperty
    a_reen_clear: assert property (p_reen_clear) else $error("busy flag not cleared");

    property p_lock_mono;
        (o_lock & ~$past(o_lock)) == 6'h00;
    endproperty
    a_lock_mono: assert property (p_lock_mono) else $error("lock bit unprogrammed");

    property p_lock_read;
        q.st == fspc_pkg::FSPC_BUSY && q.kind == fspc_pkg::FSPC_K_LOCK && !o_sect_busy
            && i_req.load |=> o_rd.valid;
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("lock op read");

    property p_rww_block;
        o_sect_busy && i_req.load && !is_no_read_while_write_section(req_page) |=> !o_rd.valid;
    endproperty
    a_rww_block: assert property (p_rww_block) else $error("busy section read");

    property p_byte_addr;
        o_rd.valid |-> {o_rd.word, o_rd.hi} == $past(i_req.ptr);
    endproperty
    a_byte_addr: assert property (p_byte_addr) else $error("load address wrong");

    property p_start_page;
        o_op.start |-> o_op.page == $past(i_req.ptr[15:`FSPC_PAGE_LSB]);
    endproperty
    a_start_page: assert property (p_start_page) else $error("op page wrong");

    property p_halt_off;
        q.st != fspc_pkg::FSPC_BUSY |-> !o_core_halt;
    endproperty
    a_halt_off: assert property (p_halt_off) else $error("halt outside op");

    property p_busy_hold;
        o_sect_busy && !(i_csr.we && i_csr.wdata[`FSPC_REEN_BIT]) |=> o_sect_busy;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy flag dropped");

    property p_ee_lock_read;
        i_eeprom_busy && i_req.load |=> !o_ld_valid;
    endproperty
    a_ee_lock_read: assert property (p_ee_lock_read) else $error("lock read in eeprom");

    property p_ee_csr;
        q.st == fspc_pkg::FSPC_IDLE && i_eeprom_busy && i_csr.we |=> q.st == fspc_pkg::FSPC_IDLE;
    endproperty
    a_ee_csr: assert property (p_ee_csr) else $error("armed in eeprom write");

    property p_irq_quiet;
        q.st == fspc_pkg::FSPC_BUSY |-> !o_irq;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq during op");

    property p_en_clear;
        $fell(q.st == fspc_pkg::FSPC_BUSY) |-> !o_csr_rdata[`FSPC_EN_BIT];
    endproperty
    a_en_clear: assert property (p_en_clear) else $error("enable kept after op");

    property p_arm_timeout;
        q.st == fspc_pkg::FSPC_ARM && q.win == `FSPC_STORE_WIN - 3'h1
            && !(i_req.store && !i_eeprom_busy) |=> !o_csr_rdata[`FSPC_EN_BIT];
    endproperty
    a_arm_timeout: assert property (p_arm_timeout) else $error("enable not cleared");

    property p_lock_prog;
        $fell(q.st == fspc_pkg::FSPC_BUSY) && q.kind == fspc_pkg::FSPC_K_LOCK
            |-> o_lock == ($past(o_lock) & $past(q.lockv));
    endproperty
    a_lock_prog: assert property (p_lock_prog) else $error("lock bits wrong");

    property p_buf_clear;
        $fell(q.st == fspc_pkg::FSPC_BUSY) && q.kind == fspc_pkg::FSPC_K_WRITE
            |-> $past(buf_clr);
    endproperty
    a_buf_clear: assert property (p_buf_clear) else $error("buffer kept");
endmodule

// ===== tb/fspc_core_model.sv
// Processor-core model: control register writes and store/load strobes.
// Assumes the controller samples on the rising edge; it drives on the falling edge.
`timescale 1ns/1ps
module fspc_core_model
(
    // Clock
    input wire logic i_clk,
    // Requests to the controller
    output fspc_pkg::fspc_csr_type o_csr,
    output fspc_pkg::fspc_req_type o_req
);
    initial
    begin
        o_csr = '0;
        o_req = '0;
    end

    // Control write; callers do not check the EEPROM busy flag first
    task automatic csr(input logic [7:0] w);
        @(negedge i_clk);
        o_csr.we <= 1'b1;
        o_csr.wdata <= w;
        @(negedge i_clk);
        o_csr.we <= 1'b0;
        o_csr.wdata <= ~w;
    endtask

    // Store or load two cycles after the control write, inside four cycles
    task automatic req(input logic st, input logic ld, input logic [15:0] p,
        input logic [15:0] d);
        @(negedge i_clk);
        o_req.store <= st;
        o_req.load <= ld;
        o_req.ptr <= p;
        o_req.operand <= d;
        @(negedge i_clk);
        o_req.store <= 1'b0;
        o_req.load <= 1'b0;
        o_req.ptr <= ~p;
        o_req.operand <= ~d;
    endtask
endmodule

// ===== tb/flash_self_program_controller_tb.sv
// Self-checking bench for the flash self-program controller.
// Assumes a shortened operation time; the core model issues all requests.
`timescale 1ns/1ps
module flash_self_program_controller_tb;
    localparam int OPC = 20;
    logic clk;
    logic rst_b;
    logic ee_busy;
    logic ee_start;
    logic [4:0] buf_idx;
    fspc_pkg::fspc_csr_type csr;
    fspc_pkg::fspc_req_type req;
    fspc_pkg::fspc_op_type op;
    fspc_pkg::fspc_rd_type rd;
    logic [7:0] rdata;
    logic ld_valid;
    logic [7:0] ld_data;
    logic halt;
    logic irq;
    logic sbusy;
    logic [5:0] lock;
    logic [15:0] bdata;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    fspc_core_model i_core (.i_clk(clk), .o_csr(csr), .o_req(req));
    fspc_ctrl #(.P_OP_CYCLES(OPC)) i_dut (.i_clk(clk), .i_rst_b(rst_b), .i_csr(csr),
        .o_csr_rdata(rdata), .i_req(req), .o_ld_valid(ld_valid), .o_ld_data(ld_data),
        .o_core_halt(halt), .o_irq(irq), .i_eeprom_busy(ee_busy),
        .i_eeprom_wr_start(ee_start), .o_op(op), .o_rd(rd), .o_sect_busy(sbusy),
        .o_lock(lock), .i_buf_idx(buf_idx), .o_buf_data(bdata));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1)
        begin
            num_errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic conclude();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            num_errors++;
            conclude();
        end
    end

    task automatic bufchk(input logic [4:0] idx, input logic [15:0] exp, input string msg);
        @(negedge clk);
        buf_idx = idx;
        @(negedge clk);
        chk(bdata === exp, msg);
    endtask

    task automatic wait_done(input int t0);
        int n;
        n = 0;
        while (rdata[0] !== 1'b0 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        chk(cycles - t0 == OPC, "op length");
    endtask

    task automatic t_reset();
        chk(lock === 6'h3f, "lock reset");
        chk(rdata === 8'h00 && halt === 1'b0, "csr reset");
        bufchk(5'h00, 16'hffff, "buffer reset");
    endtask

    task automatic t_load();
        i_core.csr(8'h01);
        i_core.req(1'b1, 1'b0, 16'h0006, 16'h1234);
        i_core.csr(8'h01);
        i_core.req(1'b1, 1'b0, 16'h0006, 16'hbeef);
        i_core.csr(8'h01);
        i_core.req(1'b1, 1'b0, 16'h003e, 16'h5a5a);
        bufchk(5'h03, 16'h1234, "slot 3");
        bufchk(5'h1f, 16'h5a5a, "slot 31");
    endtask

    task automatic t_erase();
        int t0;
        i_core.csr(8'h83);
        chk(rdata[1:0] === 2'b11, "armed");
        i_core.req(1'b1, 1'b0, 16'h017f, 16'h0000);
        t0 = cycles;
        chk(op.start === 1'b1 && op.kind === fspc_pkg::FSPC_K_ERASE, "erase start");
        chk(op.page === 10'h005, "erase page");
        chk(sbusy === 1'b1 && halt === 1'b0, "rww erase");
        i_core.csr(8'h05);
        chk(rdata[2] === 1'b0, "busy write");
        i_core.req(1'b0, 1'b1, 16'h0010, 16'h0000);
        chk(rd.valid === 1'b0, "rww read");
        bufchk(5'h03, 16'h1234, "kept");
        wait_done(t0);
        @(negedge clk);
        chk(irq === 1'b1 && sbusy === 1'b1, "irq busy");
        i_core.csr(8'h11);
        chk(sbusy === 1'b0, "reenable");
        bufchk(5'h03, 16'hffff, "cleared");
        i_core.req(1'b0, 1'b1, 16'h0123, 16'h0000);
        chk(rd.valid === 1'b1 && rd.word === 15'h0091 && rd.hi === 1'b1, "byte rd");
    endtask

    task automatic t_write();
        int t0;
        i_core.csr(8'h03);
        i_core.req(1'b1, 1'b0, 16'he000, 16'h0000);
        t0 = cycles;
        chk(op.kind === fspc_pkg::FSPC_K_ERASE && halt === 1'b1, "no_read_while_write_section erase");
        wait_done(t0);
        i_core.csr(8'h01);
        i_core.req(1'b1, 1'b0, 16'h0000, 16'h7777);
        bufchk(5'h00, 16'h7777, "load after erase");
        i_core.csr(8'h05);
        i_core.req(1'b1, 1'b0, 16'he000, 16'h0000);
        t0 = cycles;
        chk(op.start === 1'b1 && op.kind === fspc_pkg::FSPC_K_WRITE, "write");
        chk(op.page === 10'h380 && halt === 1'b1, "no_read_while_write_section halt");
        wait_done(t0);
        @(negedge clk);
        chk(halt === 1'b0, "halt end");
        bufchk(5'h00, 16'hffff, "write clr");
        i_core.csr(8'h11);
    endtask

    task automatic t_timeout();
        i_core.csr(8'h01);
        repeat (3) @(negedge clk);
        chk(rdata[0] === 1'b1, "window open");
        @(negedge clk);
        chk(rdata[0] === 1'b0, "timeout");
        i_core.req(1'b1, 1'b0, 16'h0004, 16'h4444);
        bufchk(5'h02, 16'hffff, "late store");
    endtask

    task automatic t_lock();
        int t0;
        i_core.csr(8'h09);
        i_core.req(1'b1, 1'b0, 16'h0001, 16'h00f2);
        t0 = cycles;
        chk(op.start === 1'b1 && op.kind === fspc_pkg::FSPC_K_LOCK, "lock op");
        chk(halt === 1'b0, "no stall");
        i_core.req(1'b0, 1'b1, 16'h0010, 16'h0000);
        chk(rd.valid === 1'b1 && rd.word === 15'h0008, "read in lock op");
        wait_done(t0);
        chk(lock === 6'h32, "lock bits");
        i_core.csr(8'h09);
        i_core.req(1'b0, 1'b1, 16'h0001, 16'h0000);
        chk(ld_valid === 1'b1 && ld_data === 8'hf2, "lock read");
    endtask

    task automatic t_eeprom();
        @(negedge clk);
        ee_busy = 1'b1;
        i_core.csr(8'h09);
        chk(rdata[0] === 1'b0, "ee refuse");
        i_core.req(1'b0, 1'b1, 16'h0001, 16'h0000);
        chk(ld_valid === 1'b0, "ee read");
        ee_busy = 1'b0;
        i_core.csr(8'h01);
        ee_busy = 1'b1;
        i_core.req(1'b1, 1'b0, 16'h000a, 16'h1111);
        ee_busy = 1'b0;
        bufchk(5'h05, 16'hffff, "ee store");
        i_core.csr(8'h01);
        i_core.req(1'b1, 1'b0, 16'h0008, 16'h9999);
        bufchk(5'h04, 16'h9999, "pre ee");
        ee_start = 1'b1;
        @(negedge clk);
        ee_start = 1'b0;
        bufchk(5'h04, 16'hffff, "ee discard");
    endtask

    initial
    begin
        rst_b = 1'b0;
        ee_busy = 1'b0;
        ee_start = 1'b0;
        buf_idx = 5'h00;
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        t_reset();
        t_load();
        t_erase();
        t_write();
        t_timeout();
        t_lock();
        t_eeprom();
        conclude();
    end
endmodule
